// [hw/ars_pkg.sv]
// Purpose: Shared constants and types for the axis referencing sequencer
// Assumes: 32-bit AXI4-Lite register access, 250 MHz aclk
// Notes:   Offsets are byte addresses of aligned 32-bit words
package ars_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_PARAM    = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_POS      = 8'h0C;
  localparam logic [7:0] ADDR_CAPTURE  = 8'h10;
  localparam logic [7:0] ADDR_PRESET   = 8'h14;
  localparam logic [7:0] ADDR_VEL      = 8'h18;
  localparam logic [7:0] ADDR_ACCEL    = 8'h1C;
  localparam logic [7:0] ADDR_JERK     = 8'h20;
  localparam logic [7:0] ADDR_TARGET   = 8'h24;

  // ----------------------------------------------------------------
  // Command and status word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_ACT_LSB     = 4;
  localparam int CMD_SENS_LSB    = 8;
  localparam int ST_CODE_LSB     = 0;
  localparam int ST_ERR_BIT      = 8;
  localparam int ST_VALID_BIT    = 9;
  localparam int ST_LIMEN_BIT    = 10;
  localparam int ST_MOVING_BIT   = 11;
  localparam int ST_ESTOP_BIT    = 12;
  localparam int ST_ARMED_BIT    = 13;

  // Group state codes
  localparam logic [7:0] CODE_UNREF     = 8'h00;
  localparam logic [7:0] CODE_REFERENCE = 8'h2B;
  localparam logic [7:0] CODE_ORIGIN    = 8'h0B;

  // Reset values
  localparam logic [31:0] RST_VEL    = 32'h0000_1000;
  localparam logic [31:0] RST_ACCEL  = 32'h0001_0000;
  localparam logic [31:0] RST_JERK   = 32'h0000_0010;
  localparam logic [31:0] RST_PRESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_BEGIN     = 4'h1,
    OP_ACTION    = 4'h2,
    OP_END       = 4'h3,
    OP_PROFILE   = 4'h4,
    OP_GROUP_REL = 4'h5
  } ars_op_type;

  typedef enum logic [3:0] {
    ACT_LATCH_RISE   = 4'h0,
    ACT_LATCH_FALL   = 4'h1,
    ACT_LATCH_INDEX  = 4'h2,
    ACT_INDEX_AFTER  = 4'h3,
    ACT_POS_LOAD     = 4'h4,
    ACT_POS_PRESET   = 4'h5,
    ACT_GOTO_CAPT    = 4'h6,
    ACT_REL_STEP     = 4'h7
  } ars_act_type;

  typedef enum logic [1:0] {
    SENS_NONE = 2'h0,
    SENS_REF  = 2'h1,
    SENS_NEG  = 2'h2,
    SENS_POS  = 2'h3
  } ars_sens_type;

  typedef enum logic [2:0] {
    GRP_UNREF  = 3'b001,
    GRP_REF    = 3'b010,
    GRP_ORIGIN = 3'b100
  } ars_grp_type;

  typedef enum logic [3:0] {
    MV_IDLE  = 4'b0001,
    MV_SEEK  = 4'b0010,
    MV_STOP  = 4'b0100,
    MV_PROF  = 4'b1000
  } ars_mv_type;

  // Motion request toward the profiler
  typedef struct packed {
    logic        start;
    logic        velocity_mode;
    logic [31:0] target;
    logic [31:0] velocity;
    logic [31:0] accel;
    logic [31:0] jerk;
  } ars_prof_req_type;

  // Sensor pins toward the sequencer
  typedef struct packed {
    logic ref_sw;
    logic neg_lim;
    logic pos_lim;
    logic index;
  } ars_sens_pins_type;

endpackage

// [hw/ars_sequencer.sv]
// Purpose: Single-axis referencing sequencer with AXI4-Lite registers
// Assumes: Sensor pins and profiler done are asynchronous and synchronised here
// Notes:   Writing the command word issues the command; status reports result
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ars_sequencer #(
  parameter int POS_W = 32
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire ars_pkg::ars_sens_pins_type sens_pins,
  input  wire logic                      enc_up,
  input  wire logic                      enc_down,
  input  wire logic                      prof_done,
  output ars_pkg::ars_prof_req_type      prof_req,
  output logic                           prof_stop,
  output logic                           limit_stop_en,
  output logic                           estop
);

  if (POS_W != 32) begin : g_pos_w_chk
    $error("ars_sequencer: POS_W must be 32");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic [6:0] sync3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      sync3_r <= 7'h00;
    end else begin
      sync1_r <= {prof_done, enc_down, enc_up, sens_pins};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic ref_s, neg_s, pos_s, idx_s, up_s, dn_s, done_s, idx_rise;
  assign ref_s    = sync2_r[3];
  assign neg_s    = sync2_r[2];
  assign pos_s    = sync2_r[1];
  assign idx_s    = sync2_r[0];
  assign up_s     = sync2_r[4];
  assign dn_s     = sync2_r[5];
  assign done_s   = sync2_r[6];
  assign idx_rise = idx_s & ~sync3_r[0];

  function automatic logic sel_sensor(input logic [1:0] s, input logic [6:0] v);
    case (s)
      ars_pkg::SENS_REF: sel_sensor = v[3];
      ars_pkg::SENS_NEG: sel_sensor = v[2];
      ars_pkg::SENS_POS: sel_sensor = v[1];
      default:           sel_sensor = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_r;
  logic        aw_have_r;
  logic [31:0] wdata_r;
  logic        w_have_r;
  logic        wr_fire;

  assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r > ars_pkg::ADDR_JERK) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_cmd, wr_param, wr_preset;
  assign wr_cmd    = wr_fire & (awaddr_r == ars_pkg::ADDR_CMD);
  assign wr_param  = wr_fire & (awaddr_r == ars_pkg::ADDR_PARAM);
  assign wr_preset = wr_fire & (awaddr_r == ars_pkg::ADDR_PRESET);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  ars_pkg::ars_grp_type grp_r;
  ars_pkg::ars_mv_type  mv_r;
  logic [31:0] param_r, preset_r, pos_r, capt_r, vel_r, accel_r, jerk_r, target_r;
  logic        capt_valid_r, lim_en_r, err_r, armed_r;
  logic [3:0]  act_r;
  logic [1:0]  sens_r;
  logic [3:0]  op;
  logic [3:0]  act;
  logic [1:0]  sens;
  logic        in_ref, idle, is_begin, is_end, is_act, is_prof, is_grel;

  assign op       = wdata_r[ars_pkg::CMD_OP_LSB +: 4];
  assign act      = wdata_r[ars_pkg::CMD_ACT_LSB +: 4];
  assign sens     = wdata_r[ars_pkg::CMD_SENS_LSB +: 2];
  assign in_ref   = (grp_r == ars_pkg::GRP_REF);
  assign idle     = (mv_r == ars_pkg::MV_IDLE);
  assign is_begin = wr_cmd & (op == ars_pkg::OP_BEGIN);
  assign is_end   = wr_cmd & (op == ars_pkg::OP_END);
  assign is_act   = wr_cmd & (op == ars_pkg::OP_ACTION);
  assign is_prof  = wr_cmd & (op == ars_pkg::OP_PROFILE);
  assign is_grel  = wr_cmd & (op == ars_pkg::OP_GROUP_REL);

  // Accepted action; refusal covers wrong state, busy axis, bad sensor, stale capture
  logic sens_ok, act_ok, act_go, sens_move;
  assign sens_move = (act <= ars_pkg::ACT_INDEX_AFTER);
  always_comb begin
    sens_ok = 1'b1;
    case (act)
      ars_pkg::ACT_LATCH_RISE,
      ars_pkg::ACT_LATCH_FALL:  sens_ok = (sens != ars_pkg::SENS_NONE);
      ars_pkg::ACT_INDEX_AFTER: sens_ok = (sens == ars_pkg::SENS_REF) |
                                          (sens == ars_pkg::SENS_NEG);
      default:                  sens_ok = 1'b1;
    endcase
  end
  assign act_ok = in_ref & idle & sens_ok & (act <= ars_pkg::ACT_REL_STEP) &
                  ((act != ars_pkg::ACT_GOTO_CAPT) | capt_valid_r);
  assign act_go = is_act & act_ok;

  // ----------------------------------------------------------------
  // Group state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_r <= ars_pkg::GRP_UNREF;
    end else begin
      case (grp_r)
        ars_pkg::GRP_UNREF:  if (is_begin) grp_r <= ars_pkg::GRP_REF;
        ars_pkg::GRP_REF:    if (is_end & idle) grp_r <= ars_pkg::GRP_ORIGIN;
        ars_pkg::GRP_ORIGIN: grp_r <= ars_pkg::GRP_ORIGIN;
        default:             grp_r <= ars_pkg::GRP_UNREF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_r <= 1'b0;
    end else if (wr_cmd) begin
      err_r <= (is_begin & (grp_r != ars_pkg::GRP_UNREF)) |
               (is_end & ~(in_ref & idle)) |
               (is_act & ~act_ok) |
               (is_prof & ~in_ref) |
               (is_grel & in_ref) |
               (op == ars_pkg::OP_NONE) | (op > ars_pkg::OP_GROUP_REL);
    end
  end

  // Limit-switch safety enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim_en_r <= 1'b1;
    end else if (is_end & in_ref & idle) begin
      lim_en_r <= 1'b1;
    end else if (act_go & (sens == ars_pkg::SENS_NEG)) begin
      lim_en_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers written directly
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param_r  <= 32'h0000_0000;
      preset_r <= ars_pkg::RST_PRESET;
    end else begin
      if (wr_param) param_r <= wdata_r;
      if (wr_preset) preset_r <= wdata_r;
    end
  end

  // Profile parameters; sensor and goto moves leave their speed behind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vel_r   <= ars_pkg::RST_VEL;
      accel_r <= ars_pkg::RST_ACCEL;
      jerk_r  <= ars_pkg::RST_JERK;
    end else if (is_prof & in_ref) begin
      vel_r   <= param_r;
      accel_r <= wdata_r[31:16] == 16'h0000 ? accel_r : {16'h0000, wdata_r[31:16]};
      jerk_r  <= {24'h00_0000, wdata_r[15:8]};
    end else if (act_go & (sens_move | (act == ars_pkg::ACT_GOTO_CAPT))) begin
      vel_r <= param_r[31] ? 32'(-param_r) : param_r;
    end
  end

  // ----------------------------------------------------------------
  // Motion sequencer
  // ----------------------------------------------------------------
  logic edge_hit;
  always_comb begin
    edge_hit = 1'b0;
    case (act_r)
      ars_pkg::ACT_LATCH_RISE:  edge_hit = sel_sensor(sens_r, sync2_r) &
                                           ~sel_sensor(sens_r, sync3_r);
      ars_pkg::ACT_LATCH_FALL:  edge_hit = ~sel_sensor(sens_r, sync2_r) &
                                           sel_sensor(sens_r, sync3_r);
      ars_pkg::ACT_LATCH_INDEX: edge_hit = idx_rise;
      ars_pkg::ACT_INDEX_AFTER: edge_hit = armed_r & idx_rise;
      default:                  edge_hit = 1'b0;
    endcase
  end

  logic hit;
  assign hit = (mv_r == ars_pkg::MV_SEEK) & edge_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
    end else if (act_go) begin
      armed_r <= 1'b0;
    end else if ((mv_r == ars_pkg::MV_SEEK) & ~sel_sensor(sens_r, sync2_r) &
                 sel_sensor(sens_r, sync3_r)) begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mv_r   <= ars_pkg::MV_IDLE;
      act_r  <= 4'h0;
      sens_r <= 2'h0;
    end else begin
      case (mv_r)
        ars_pkg::MV_IDLE: begin
          if (act_go) begin
            act_r  <= act;
            sens_r <= sens;
            if (sens_move) mv_r <= ars_pkg::MV_SEEK;
            else if (act >= ars_pkg::ACT_GOTO_CAPT) mv_r <= ars_pkg::MV_PROF;
          end
        end
        ars_pkg::MV_SEEK: if (hit | estop) mv_r <= ars_pkg::MV_STOP;
        ars_pkg::MV_STOP: if (done_s) mv_r <= ars_pkg::MV_IDLE;
        ars_pkg::MV_PROF: if (done_s) mv_r <= ars_pkg::MV_IDLE;
        default:          mv_r <= ars_pkg::MV_IDLE;
      endcase
    end
  end

  // Capture latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capt_r       <= 32'h0000_0000;
      capt_valid_r <= 1'b0;
    end else if (hit) begin
      capt_r       <= pos_r;
      capt_valid_r <= 1'b1;
    end else if (is_begin & (grp_r == ars_pkg::GRP_UNREF)) begin
      capt_valid_r <= 1'b0;
    end
  end

  // Position counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= 32'h0000_0000;
    end else if (act_go & (act == ars_pkg::ACT_POS_LOAD)) begin
      pos_r <= param_r;
    end else if (act_go & (act == ars_pkg::ACT_POS_PRESET)) begin
      pos_r <= preset_r;
    end else if (up_s & ~dn_s) begin
      pos_r <= pos_r + 32'h0000_0001;
    end else if (dn_s & ~up_s) begin
      pos_r <= pos_r - 32'h0000_0001;
    end
  end

  // Profiler request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prof_req  <= '0;
      prof_stop <= 1'b0;
      target_r  <= 32'h0000_0000;
    end else begin
      prof_req.start <= 1'b0;
      prof_stop      <= hit | ((mv_r == ars_pkg::MV_SEEK) & estop);
      if (act_go & sens_move) begin
        prof_req.start         <= 1'b1;
        prof_req.velocity_mode <= 1'b1;
        prof_req.velocity      <= param_r;
        prof_req.accel         <= accel_r;
        prof_req.jerk          <= jerk_r;
      end else if (act_go & (act == ars_pkg::ACT_GOTO_CAPT)) begin
        prof_req.start         <= 1'b1;
        prof_req.velocity_mode <= 1'b0;
        prof_req.target        <= capt_r;
        prof_req.velocity      <= param_r[31] ? 32'(-param_r) : param_r;
        prof_req.accel         <= accel_r;
        prof_req.jerk          <= jerk_r;
        target_r               <= capt_r;
      end else if (act_go & (act == ars_pkg::ACT_REL_STEP)) begin
        prof_req.start         <= 1'b1;
        prof_req.velocity_mode <= 1'b0;
        prof_req.target        <= pos_r + param_r;
        prof_req.velocity      <= vel_r;
        prof_req.accel         <= accel_r;
        prof_req.jerk          <= jerk_r;
        target_r               <= pos_r + param_r;
      end
    end
  end

  // Limit-switch emergency stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      estop         <= 1'b0;
      limit_stop_en <= 1'b1;
    end else begin
      limit_stop_en <= lim_en_r;
      estop         <= lim_en_r & (neg_s | pos_s) & ~idle;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [7:0] code;
  always_comb begin
    case (grp_r)
      ars_pkg::GRP_REF:    code = ars_pkg::CODE_REFERENCE;
      ars_pkg::GRP_ORIGIN: code = ars_pkg::CODE_ORIGIN;
      default:             code = ars_pkg::CODE_UNREF;
    endcase
  end

  logic [31:0] rd_mux;
  logic        rd_bad;
  always_comb begin
    rd_bad = 1'b0;
    case (s_axi_araddr)
      ars_pkg::ADDR_CMD:     rd_mux = wdata_r;
      ars_pkg::ADDR_PARAM:   rd_mux = param_r;
      ars_pkg::ADDR_STATUS:  rd_mux = {18'h0_0000, armed_r, estop, ~idle, lim_en_r,
                                       capt_valid_r, err_r, code};
      ars_pkg::ADDR_POS:     rd_mux = pos_r;
      ars_pkg::ADDR_CAPTURE: rd_mux = capt_r;
      ars_pkg::ADDR_PRESET:  rd_mux = preset_r;
      ars_pkg::ADDR_VEL:     rd_mux = vel_r;
      ars_pkg::ADDR_ACCEL:   rd_mux = accel_r;
      ars_pkg::ADDR_JERK:    rd_mux = jerk_r;
      ars_pkg::ADDR_TARGET:  rd_mux = target_r;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_bad ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [verif/ars_prof_model.sv]
// Purpose: Profiler stand-in answering start and stop requests
// Assumes: Velocity moves run until stopped, target moves end alone
// Notes:   Done is high a few cycles near the end, low otherwise
`timescale 1ns/1ps
module ars_prof_model (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire ars_pkg::ars_prof_req_type prof_req,
  input  wire logic                      prof_stop,
  output logic                           prof_done
);
  logic [3:0] cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r     <= 4'h0;
      prof_done <= 1'b0;
    end else begin
      if (prof_stop)
        cnt_r <= 4'h6;
      else if (prof_req.start)
        cnt_r <= prof_req.velocity_mode ? 4'h0 : 4'h9;
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      prof_done <= (cnt_r > 4'h1) && (cnt_r < 4'h5);
    end
  end
endmodule

// [verif/ars_seq_monitor.sv]
// Purpose: Port-level checks on the referencing sequencer
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound onto every sequencer instance
`timescale 1ns/1ps
module ars_seq_monitor (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire ars_pkg::ars_prof_req_type prof_req,
  input wire logic                      prof_stop,
  input wire logic                      limit_stop_en,
  input wire logic                      estop
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic bfire;
  assign bfire = s_axi_bvalid && s_axi_bready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_DONE: assert property (bfire |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
  AST_R_ANS: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_START_CAUSE: assert property (prof_req.start |-> $rose(s_axi_bvalid))
    else $error("move started without a command");
  AST_STOP_PULSE: assert property (prof_stop |=> !prof_stop [*3])
    else $error("stop request repeated");
  AST_LIM_ON: assert property ($rose(limit_stop_en) |-> $past(bfire))
    else $error("safeties enabled without a command");
  AST_LIM_OFF: assert property ($fell(limit_stop_en) |-> $past(bfire))
    else $error("safeties disabled without a command");
  AST_ESTOP: assert property ($rose(estop) |-> $past(limit_stop_en))
    else $error("emergency stop with safeties off");
endmodule

bind ars_sequencer ars_seq_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .prof_req(prof_req),
  .prof_stop(prof_stop), .limit_stop_en(limit_stop_en), .estop(estop));

// [verif/ars_sequencer_tb.sv]
// Purpose: Self-checking bench for the referencing sequencer
// Assumes: Encoder still except one counting burst, so captures equal the position
// Notes:   Profiler model answers every move
`timescale 1ns/1ps
module ars_sequencer_tb;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        prof_stop, lim_en, estop, done;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd, lvel, ltgt;
  logic [1:0]  bresp, rresp, lbresp;
  logic [3:0]  pins = 0;
  logic        up = 0;
  ars_pkg::ars_prof_req_type req;
  int          err_total = 0, checks_done = 0, stops = 0, cyc = 0;
  always #2 aclk = ~aclk;
  ars_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sens_pins(pins), .enc_up(up), .enc_down(1'b0),
    .prof_done(done), .prof_req(req), .prof_stop(prof_stop), .limit_stop_en(lim_en),
    .estop(estop));
  ars_prof_model pm_u (.aclk(aclk), .aresetn(aresetn), .prof_req(req),
    .prof_stop(prof_stop), .prof_done(done));
  always @(posedge aclk) begin
    cyc++;
    if (req.start === 1'b1) begin
      lvel = req.velocity;
      ltgt = req.target;
    end
    if (prof_stop === 1'b1)
      stops++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    lbresp = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic cmd(input logic [3:0] op, a, input logic [1:0] s, input logic [31:0] p);
    wr(ars_pkg::ADDR_PARAM, p);
    wr(ars_pkg::ADDR_CMD, {22'h0, s, a, op});
  endtask
  task automatic st(input logic [7:0] c, input logic e);
    rdr(ars_pkg::ADDR_STATUS);
    chk({23'h0, e, c}, {23'h0, rd[8:0]});
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      rdr(ars_pkg::ADDR_STATUS);
      n++;
    end while (rd[11] !== 1'b0 && n < 40);
    chk(0, rd[11]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_latch(input logic [3:0] a, input logic [1:0] s, input logic [3:0] p0, p1, p2);
    int n;
    n = stops;
    pins <= p0;
    cmd(ars_pkg::OP_ACTION, a, s, 32'hFFFF_F000);
    repeat (6) @(posedge aclk);
    pins <= p1;
    repeat (6) @(posedge aclk);
    pins <= p2;
    idle();
    chk({30'h0, rd[9:8]}, 32'h0000_0002);
    chk(32'hFFFF_F000, lvel);
    chk(n + 1, stops);
    rdr(ars_pkg::ADDR_CAPTURE);
    chk(32'h0000_0055, rd);
  endtask
  task automatic t_start();
    chk(1, lim_en);
    st(ars_pkg::CODE_UNREF, 0);
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_POS_LOAD, 0, 32'h0000_0077);
    st(ars_pkg::CODE_UNREF, 1);
    rdr(ars_pkg::ADDR_POS);
    chk(0, rd);
    wr(8'h28, 0);
    chk(2, lbresp);
    rdr(8'h28);
    chk(2, rresp);
    cmd(ars_pkg::OP_BEGIN, 0, 0, 0);
    st(ars_pkg::CODE_REFERENCE, 0);
    cmd(ars_pkg::OP_BEGIN, 0, 0, 0);
    st(ars_pkg::CODE_REFERENCE, 1);
    cmd(ars_pkg::OP_GROUP_REL, 0, 0, 32'h0000_0040);
    st(ars_pkg::CODE_REFERENCE, 1);
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_GOTO_CAPT, 0, 32'h0000_0300);
    st(ars_pkg::CODE_REFERENCE, 1);
  endtask
  task automatic t_load();
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_POS_LOAD, 0, 32'h0000_1234);
    rdr(ars_pkg::ADDR_POS);
    chk(32'h0000_1234, rd);
    wr(ars_pkg::ADDR_PRESET, 32'h0000_0055);
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_POS_PRESET, 0, 0);
    rdr(ars_pkg::ADDR_POS);
    chk(32'h0000_0055, rd);
  endtask
  task automatic t_estop();
    int n;
    n = stops;
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_LATCH_RISE, ars_pkg::SENS_REF, 32'h0000_0100);
    repeat (6) @(posedge aclk);
    pins <= 4'h4;
    repeat (4) @(posedge aclk);
    chk(1, estop);
    idle();
    chk(n + 1, stops);
    chk(0, estop);
  endtask
  task automatic t_moves();
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_GOTO_CAPT, 0, 32'h0000_0300);
    idle();
    chk(0, rd[8]);
    chk(32'h0000_0300, lvel);
    chk(32'h0000_0055, ltgt);
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_REL_STEP, 0, 32'h0000_0010);
    idle();
    chk(32'h0000_0300, lvel);
    cmd(ars_pkg::OP_PROFILE, 0, 0, 32'h0000_0500);
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_REL_STEP, 0, 32'h0000_0010);
    idle();
    chk(32'h0000_0500, lvel);
    rdr(ars_pkg::ADDR_POS);
    chk(32'h0000_0055, rd);
    up <= 1;
    repeat (5) @(posedge aclk);
    up <= 0;
    rdr(ars_pkg::ADDR_CAPTURE);
    chk(32'h0000_0055, rd);
    rdr(ars_pkg::ADDR_POS);
    chk(32'h0000_005A, rd);
  endtask
  task automatic t_end();
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_POS_PRESET, 0, 0);
    cmd(ars_pkg::OP_END, 0, 0, 0);
    st(8'h0B, 0);
    chk(1, lim_en);
    cmd(ars_pkg::OP_ACTION, ars_pkg::ACT_POS_LOAD, 0, 32'h0000_0099);
    st(8'h0B, 1);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_start();
    t_load();
    t_latch(ars_pkg::ACT_LATCH_RISE, ars_pkg::SENS_REF, 4'h0, 4'h8, 4'h8);
    t_latch(ars_pkg::ACT_LATCH_FALL, ars_pkg::SENS_REF, 4'h8, 4'h0, 4'h0);
    t_latch(ars_pkg::ACT_LATCH_INDEX, ars_pkg::SENS_NONE, 4'h0, 4'h1, 4'h0);
    chk(1, lim_en);
    t_estop();
    t_latch(ars_pkg::ACT_INDEX_AFTER, ars_pkg::SENS_NEG, 4'h4, 4'h0, 4'h1);
    chk(0, lim_en);
    t_latch(ars_pkg::ACT_LATCH_RISE, ars_pkg::SENS_POS, 4'h0, 4'h2, 4'h2);
    t_moves();
    t_end();
    final_report();
  end
endmodule
